// [hw/scrb_top.sv]
// Serial-access configuration register bank of the four-to-one link switch
//
// Function
// - All registers read and written by the serial master over data and clock lines.
// - Address low bits come from three strap inputs; only that address answers.
// - Any serial access to this device address disables the parallel control path until reset.
// - Fast route register at 0x00 resets 0x40: enable bit 6, source bits 1:0.
// - Fast enable 0 turns channels off into standby; 1 lets them run.
// - Fast source code 00..11 routes source A..D lanes to output.
// - Side route register at 0x01 resets 0x40: enable bit 6, source bits 1:0.
// - Side enable 0 opens the auxiliary switch; 1 closes it.
// - Side source code 00..11 connects auxiliary lines of A..D to common port.
// - Receiver register at 0x10 resets 0x01; master bit 0 low opens all terminations.
// - Master bit high lets each lane follow its per-lane termination bit.
// - Register 0x11 resets zero, holds lane termination bits 7:0.
// - Register 0x12 resets zero, holds lane termination bits 15:8.
// - Lane termination bit 0 disconnects, 1 connects that lane.
// - Lane equalizer bit 0 selects low level, 1 high level.
// - Output boost code 00 none, 01 low, 10 medium, 11 high.
// - Drive bit selects lower or higher current; output term bit off or on.
`default_nettype none
module scrb_top
  import scrb_pkg::*;
(
  input  wire logic      ref_clk_i,
  input  wire logic      rst_n_i,
  input  wire logic      scl_i,
  input  wire logic      sda_i,
  output logic           sda_o,
  output logic           sda_oe_o,
  input  wire logic      addr_strap_2_i,
  input  wire logic      addr_strap_1_i,
  input  wire logic      addr_strap_0_i,
  output logic           parallel_lock_o,
  output scrb_cfg_t      cfg_o
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  scrb_state_t state_reg;
  logic [3:0]  cnt_reg;
  logic [7:0]  shift_reg;
  logic [7:0]  ptr_reg;
  logic        rw_reg;
  logic        nack_reg;
  logic        scl_prev_reg;
  logic        sda_prev_reg;
  logic        lock_reg;
  logic [7:0]  fast_route_reg;
  logic [7:0]  side_route_reg;
  logic [7:0]  term_master_reg;
  logic [7:0]  term_lo_reg;
  logic [7:0]  term_hi_reg;
  logic [7:0]  eq_lo_reg;
  logic [7:0]  eq_hi_reg;
  logic [7:0]  drive_reg;
  logic [7:0]  rd_data;
  logic [6:0]  own_addr;
  logic        scl_rise;
  logic        scl_fall;
  logic        bus_start;
  logic        bus_stop;
  logic        byte_end;
  logic        addr_match;
  logic        wr_stb;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [3:0] src_decode(input logic [1:0] code, input logic on);
    logic [3:0] sel;
    sel = 4'h0;
    case (code)
      SCRB_SRC_A: sel = 4'h1;
      SCRB_SRC_B: sel = 4'h2;
      SCRB_SRC_C: sel = 4'h4;
      SCRB_SRC_D: sel = 4'h8;
      default:    sel = 4'h0;
    endcase
    return on ? sel : 4'h0;
  endfunction

  // ------------------------------------------------------------------
  // Line sampling and bus conditions
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end
    else
    begin
      scl_prev_reg <= scl_i;
      sda_prev_reg <= sda_i;
    end
  end

  assign scl_rise   = scl_i & ~scl_prev_reg;
  assign scl_fall   = ~scl_i & scl_prev_reg;
  assign bus_start  = scl_i & scl_prev_reg & sda_prev_reg & ~sda_i;
  assign bus_stop   = scl_i & scl_prev_reg & ~sda_prev_reg & sda_i;
  assign byte_end   = scl_fall & (cnt_reg == 4'h8);
  assign own_addr   = {SCRB_DEV_ADDR_HI, addr_strap_2_i, addr_strap_1_i, addr_strap_0_i};
  assign addr_match = (shift_reg[7:1] == own_addr);
  assign wr_stb     = (state_reg == SCRB_ST_WR_DATA) & byte_end;

  // ------------------------------------------------------------------
  // Serial protocol engine
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= SCRB_ST_IDLE;
      cnt_reg   <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg   <= 8'h00;
      rw_reg    <= 1'b0;
      nack_reg  <= 1'b0;
    end
    else if (bus_start)
    begin
      state_reg <= SCRB_ST_DEV_ADDR;
      cnt_reg   <= 4'h0;
    end
    else if (bus_stop)
    begin
      state_reg <= SCRB_ST_IDLE;
    end
    else
    begin
      case (state_reg)
        SCRB_ST_DEV_ADDR,
        SCRB_ST_REG_ADDR,
        SCRB_ST_WR_DATA:
        begin
          if (scl_rise)
          begin
            shift_reg <= {shift_reg[6:0], sda_i};
            cnt_reg   <= cnt_reg + 4'h1;
          end
          else if (byte_end)
          begin
            cnt_reg <= 4'h0;
            if (state_reg == SCRB_ST_DEV_ADDR)
            begin
              rw_reg    <= shift_reg[0];
              state_reg <= addr_match ? SCRB_ST_DEV_ACK : SCRB_ST_IDLE;
            end
            else if (state_reg == SCRB_ST_REG_ADDR)
            begin
              ptr_reg   <= shift_reg;
              state_reg <= SCRB_ST_REG_ACK;
            end
            else
            begin
              state_reg <= SCRB_ST_WR_ACK;
            end
          end
        end
        SCRB_ST_DEV_ACK:
        begin
          if (scl_fall)
          begin
            cnt_reg <= 4'h0;
            if (rw_reg)
            begin
              shift_reg <= rd_data;
              state_reg <= SCRB_ST_RD_DATA;
            end
            else
            begin
              state_reg <= SCRB_ST_REG_ADDR;
            end
          end
        end
        SCRB_ST_REG_ACK,
        SCRB_ST_WR_ACK:
        begin
          if (scl_fall)
          begin
            cnt_reg   <= 4'h0;
            state_reg <= SCRB_ST_WR_DATA;
          end
        end
        SCRB_ST_RD_DATA:
        begin
          if (scl_rise)
          begin
            cnt_reg <= cnt_reg + 4'h1;
          end
          else if (byte_end)
          begin
            cnt_reg   <= 4'h0;
            state_reg <= SCRB_ST_RD_ACK;
          end
          else if (scl_fall)
          begin
            shift_reg <= {shift_reg[6:0], 1'b0};
          end
        end
        SCRB_ST_RD_ACK:
        begin
          if (scl_rise)
          begin
            nack_reg <= sda_i;
          end
          else if (scl_fall)
          begin
            if (nack_reg)
            begin
              state_reg <= SCRB_ST_IDLE;
            end
            else
            begin
              shift_reg <= rd_data;
              state_reg <= SCRB_ST_RD_DATA;
            end
          end
        end
        default:
        begin
          state_reg <= SCRB_ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Open-drain data line
  // ------------------------------------------------------------------
  assign sda_o    = 1'b0;
  assign sda_oe_o = (state_reg == SCRB_ST_DEV_ACK) |
                    (state_reg == SCRB_ST_REG_ACK) |
                    (state_reg == SCRB_ST_WR_ACK)  |
                    ((state_reg == SCRB_ST_RD_DATA) & ~shift_reg[7]);

  // ------------------------------------------------------------------
  // Parallel path lockout
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      lock_reg <= 1'b0;
    end
    else if ((state_reg == SCRB_ST_DEV_ADDR) & byte_end & addr_match)
    begin
      lock_reg <= 1'b1;
    end
  end

  assign parallel_lock_o = lock_reg;

  // ------------------------------------------------------------------
  // Register bank
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      fast_route_reg  <= SCRB_RST_FAST;
      side_route_reg  <= SCRB_RST_SIDE;
      term_master_reg <= SCRB_RST_TERM_M;
      term_lo_reg     <= SCRB_RST_TERM_LO;
      term_hi_reg     <= SCRB_RST_TERM_HI;
      eq_lo_reg       <= SCRB_RST_EQ_LO;
      eq_hi_reg       <= SCRB_RST_EQ_HI;
      drive_reg       <= SCRB_RST_DRIVE;
    end
    else if (wr_stb)
    begin
      case (ptr_reg)
        SCRB_OFS_FAST:    fast_route_reg  <= shift_reg & SCRB_MSK_ROUTE;
        SCRB_OFS_SIDE:    side_route_reg  <= shift_reg & SCRB_MSK_ROUTE;
        SCRB_OFS_TERM_M:  term_master_reg <= shift_reg & SCRB_MSK_TERM_M;
        SCRB_OFS_TERM_LO: term_lo_reg     <= shift_reg & SCRB_MSK_LANE;
        SCRB_OFS_TERM_HI: term_hi_reg     <= shift_reg & SCRB_MSK_LANE;
        SCRB_OFS_EQ_LO:   eq_lo_reg       <= shift_reg & SCRB_MSK_LANE;
        SCRB_OFS_EQ_HI:   eq_hi_reg       <= shift_reg & SCRB_MSK_LANE;
        SCRB_OFS_DRIVE:   drive_reg       <= shift_reg & SCRB_MSK_DRIVE;
        default:          ;
      endcase
    end
  end

  always_comb
  begin
    case (ptr_reg)
      SCRB_OFS_FAST:    rd_data = fast_route_reg;
      SCRB_OFS_SIDE:    rd_data = side_route_reg;
      SCRB_OFS_TERM_M:  rd_data = term_master_reg;
      SCRB_OFS_TERM_LO: rd_data = term_lo_reg;
      SCRB_OFS_TERM_HI: rd_data = term_hi_reg;
      SCRB_OFS_EQ_LO:   rd_data = eq_lo_reg;
      SCRB_OFS_EQ_HI:   rd_data = eq_hi_reg;
      SCRB_OFS_DRIVE:   rd_data = drive_reg;
      default:          rd_data = 8'h00;
    endcase
  end

  // ------------------------------------------------------------------
  // Effective configuration
  // ------------------------------------------------------------------
  always_comb
  begin
    cfg_o.fast_path_on        = fast_route_reg[SCRB_POS_ROUTE_ON];
    cfg_o.fast_standby        = ~fast_route_reg[SCRB_POS_ROUTE_ON];
    cfg_o.fast_source_pick    = fast_route_reg[SCRB_POS_PICK_LSB +: 2];
    cfg_o.fast_source_sel     = src_decode(fast_route_reg[SCRB_POS_PICK_LSB +: 2],
                                           fast_route_reg[SCRB_POS_ROUTE_ON]);
    cfg_o.side_path_on        = side_route_reg[SCRB_POS_ROUTE_ON];
    cfg_o.side_source_pick    = side_route_reg[SCRB_POS_PICK_LSB +: 2];
    cfg_o.side_common_port    = src_decode(side_route_reg[SCRB_POS_PICK_LSB +: 2],
                                           side_route_reg[SCRB_POS_ROUTE_ON]);
    cfg_o.input_term_per_lane = term_master_reg[SCRB_POS_TERM_M] ?
                                {term_hi_reg, term_lo_reg} : 16'h0000;
    cfg_o.input_eq_level      = {eq_hi_reg, eq_lo_reg};
    cfg_o.output_boost_level  = drive_reg[SCRB_POS_BOOST_LSB +: 2];
    cfg_o.output_term_on      = drive_reg[SCRB_POS_OTERM];
    cfg_o.output_drive_level  = drive_reg[SCRB_POS_DRIVE];
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  sequence s_own_addr_byte;
    (state_reg == SCRB_ST_DEV_ADDR) && byte_end && addr_match;
  endsequence

  sequence s_foreign_addr_byte;
    (state_reg == SCRB_ST_DEV_ADDR) && byte_end && !addr_match && !bus_start && !bus_stop;
  endsequence

  AST_ACK_OWN_ADDR: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    s_own_addr_byte ##0 !bus_start && !bus_stop |=> (state_reg == SCRB_ST_DEV_ACK) && sda_oe_o)
    else $error("own address not acknowledged");

  AST_IGNORE_FOREIGN: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    s_foreign_addr_byte |=> (state_reg == SCRB_ST_IDLE) && !sda_oe_o &&
                            (lock_reg == $past(lock_reg)))
    else $error("foreign address answered");

  AST_LOCK_ON_ACCESS: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    s_own_addr_byte |=> parallel_lock_o)
    else $error("serial access did not lock parallel path");

  AST_LOCK_STICKY: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    parallel_lock_o |=> parallel_lock_o)
    else $error("parallel lockout released before reset");

  AST_RESET_VALUES: assert property (@(posedge ref_clk_i)
    $rose(rst_n_i) |-> (fast_route_reg == 8'h40) && (side_route_reg == 8'h40) &&
                       (term_master_reg == 8'h01) && (drive_reg == 8'h03) && !parallel_lock_o)
    else $error("register reset value wrong");

  AST_STANDBY: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    cfg_o.fast_standby |-> (cfg_o.fast_source_sel == 4'h0) && !cfg_o.fast_path_on)
    else $error("standby with fast path routed");

  AST_SIDE_OPEN: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !cfg_o.side_path_on |-> (cfg_o.side_common_port == 4'h0))
    else $error("side switch closed while disabled");

  AST_TERM_MASTER: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (term_master_reg[0] ? cfg_o.input_term_per_lane == {term_hi_reg, term_lo_reg}
                        : cfg_o.input_term_per_lane == 16'h0000))
    else $error("termination master gating wrong");

  AST_WRITE_DRIVE: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_stb && (ptr_reg == 8'h20) |=> drive_reg == ($past(shift_reg) & 8'h0F))
    else $error("drive register write lost or reserved bits kept");

  AST_RSVD_ZERO: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ((fast_route_reg & 8'hBC) == 8'h00) && ((side_route_reg & 8'hBC) == 8'h00) &&
    (term_master_reg[7:1] == 7'h00) && (drive_reg[7:4] == 4'h0))
    else $error("reserved bit set");

  AST_READ_LOAD: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (state_reg == SCRB_ST_DEV_ACK) && scl_fall && rw_reg && !bus_start && !bus_stop
    |=> (state_reg == SCRB_ST_RD_DATA) && (shift_reg == $past(rd_data)))
    else $error("read data not loaded after acknowledge");

endmodule
`default_nettype wire

// [hw/scrb_pkg.sv]
// Constants and carrier types for the switch configuration register bank
`default_nettype none
package scrb_pkg;

  // ------------------------------------------------------------------
  // Serial bus address
  // ------------------------------------------------------------------
  localparam logic [3:0] SCRB_DEV_ADDR_HI  = 4'h9;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] SCRB_OFS_FAST     = 8'h00;
  localparam logic [7:0] SCRB_OFS_SIDE     = 8'h01;
  localparam logic [7:0] SCRB_OFS_TERM_M   = 8'h10;
  localparam logic [7:0] SCRB_OFS_TERM_LO  = 8'h11;
  localparam logic [7:0] SCRB_OFS_TERM_HI  = 8'h12;
  localparam logic [7:0] SCRB_OFS_EQ_LO    = 8'h13;
  localparam logic [7:0] SCRB_OFS_EQ_HI    = 8'h14;
  localparam logic [7:0] SCRB_OFS_DRIVE    = 8'h20;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] SCRB_RST_FAST     = 8'h40;
  localparam logic [7:0] SCRB_RST_SIDE     = 8'h40;
  localparam logic [7:0] SCRB_RST_TERM_M   = 8'h01;
  localparam logic [7:0] SCRB_RST_TERM_LO  = 8'h00;
  localparam logic [7:0] SCRB_RST_TERM_HI  = 8'h00;
  localparam logic [7:0] SCRB_RST_EQ_LO    = 8'h00;
  localparam logic [7:0] SCRB_RST_EQ_HI    = 8'h00;
  localparam logic [7:0] SCRB_RST_DRIVE    = 8'h03;

  // ------------------------------------------------------------------
  // Writable bit masks
  // ------------------------------------------------------------------
  localparam logic [7:0] SCRB_MSK_ROUTE    = 8'h43;
  localparam logic [7:0] SCRB_MSK_TERM_M   = 8'h01;
  localparam logic [7:0] SCRB_MSK_LANE     = 8'hFF;
  localparam logic [7:0] SCRB_MSK_DRIVE    = 8'h0F;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int SCRB_POS_ROUTE_ON   = 6;
  localparam int SCRB_POS_PICK_LSB   = 0;
  localparam int SCRB_POS_TERM_M     = 0;
  localparam int SCRB_POS_BOOST_LSB  = 2;
  localparam int SCRB_POS_OTERM      = 1;
  localparam int SCRB_POS_DRIVE      = 0;

  // ------------------------------------------------------------------
  // Source codes
  // ------------------------------------------------------------------
  localparam logic [1:0] SCRB_SRC_A = 2'h0;
  localparam logic [1:0] SCRB_SRC_B = 2'h1;
  localparam logic [1:0] SCRB_SRC_C = 2'h2;
  localparam logic [1:0] SCRB_SRC_D = 2'h3;

  // ------------------------------------------------------------------
  // Serial protocol states
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    SCRB_ST_IDLE,
    SCRB_ST_DEV_ADDR,
    SCRB_ST_DEV_ACK,
    SCRB_ST_REG_ADDR,
    SCRB_ST_REG_ACK,
    SCRB_ST_WR_DATA,
    SCRB_ST_WR_ACK,
    SCRB_ST_RD_DATA,
    SCRB_ST_RD_ACK
  } scrb_state_t;

  // ------------------------------------------------------------------
  // Effective configuration carried to the switch
  // ------------------------------------------------------------------
  typedef struct packed {
    logic        fast_path_on;
    logic        fast_standby;
    logic [1:0]  fast_source_pick;
    logic [3:0]  fast_source_sel;
    logic        side_path_on;
    logic [1:0]  side_source_pick;
    logic [3:0]  side_common_port;
    logic [15:0] input_term_per_lane;
    logic [15:0] input_eq_level;
    logic [1:0]  output_boost_level;
    logic        output_term_on;
    logic        output_drive_level;
  } scrb_cfg_t;

endpackage
`default_nettype wire

// [testbench/scrb_master.sv]
// Two-wire serial bus master model driving the register bank
`default_nettype none
module scrb_master
(
  input  wire logic ref_clk_i,
  input  wire logic sda_line_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Clocks per quarter of a serial bit; raised for a slow master
  int hp = 2;

  initial
  begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask

  // ------------------------------------------------------------------
  // Framing, start and stop change data while the clock line is high
  // ------------------------------------------------------------------
  task automatic start_cond();
    tick(hp);
    sda_low_o = 1'b0;
    tick(hp);
    scl_o = 1'b1;
    tick(2 * hp);
    sda_low_o = 1'b1;
    tick(2 * hp);
    scl_o = 1'b0;
  endtask

  task automatic stop_cond();
    tick(hp);
    sda_low_o = 1'b1;
    tick(hp);
    scl_o = 1'b1;
    tick(2 * hp);
    sda_low_o = 1'b0;
    tick(2 * hp);
  endtask

  // ------------------------------------------------------------------
  // Bit and byte transfer, MSB first; released line reads the pull-up
  // ------------------------------------------------------------------
  task automatic bit_io(input logic b, output logic seen);
    tick(hp);
    sda_low_o = ~b;
    tick(hp);
    scl_o = 1'b1;
    tick(2 * hp);
    seen  = sda_line_i;
    scl_o = 1'b0;
  endtask

  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  task automatic byte_in(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(~ack, s);
  endtask
endmodule
`default_nettype wire

// [testbench/scrb_top_test.sv]
// Self-checking bench for the switch configuration register bank
`default_nettype none
module scrb_top_test
  import scrb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       ref_clk = 1'b0;
  logic       rst_n   = 1'b0;
  logic [2:0] strap   = 3'h5;
  logic       scl;
  logic       mst_low;
  logic       sda_line;
  logic       sda_o_w;
  logic       sda_oe_w;
  logic       lock_w;
  scrb_cfg_t  cfg_w;
  logic [7:0] rd_v;
  logic       ack_v;
  int         err_total = 0;
  int         checked   = 0;

  localparam logic [7:0] OFS_TAB [8] = '{SCRB_OFS_FAST, SCRB_OFS_SIDE, SCRB_OFS_TERM_M,
    SCRB_OFS_TERM_LO, SCRB_OFS_TERM_HI, SCRB_OFS_EQ_LO, SCRB_OFS_EQ_HI, SCRB_OFS_DRIVE};
  localparam logic [7:0] RST_TAB [8] = '{8'h40, 8'h40, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03};

  initial
  forever #5 ref_clk = ~ref_clk;

  // Open-drain data line with pull-up
  assign sda_line = ~mst_low & ~(sda_oe_w & ~sda_o_w);

  scrb_top dut (
    .ref_clk_i       (ref_clk),
    .rst_n_i         (rst_n),
    .scl_i           (scl),
    .sda_i           (sda_line),
    .sda_o           (sda_o_w),
    .sda_oe_o        (sda_oe_w),
    .addr_strap_2_i  (strap[2]),
    .addr_strap_1_i  (strap[1]),
    .addr_strap_0_i  (strap[0]),
    .parallel_lock_o (lock_w),
    .cfg_o           (cfg_w)
  );

  scrb_master mst (
    .ref_clk_i  (ref_clk),
    .sda_line_i (sda_line),
    .scl_o      (scl),
    .sda_low_o  (mst_low)
  );

  // ------------------------------------------------------------------
  // Compare, bus and closing tasks
  // ------------------------------------------------------------------
  task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_ack(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    logic a0;
    logic a1;
    logic a2;
    mst.start_cond();
    mst.byte_out({SCRB_DEV_ADDR_HI, strap, 1'b0}, a0);
    mst.byte_out(ofs, a1);
    mst.byte_out(d, a2);
    mst.stop_cond();
    chk_ack("write ack", 1'b1, a0 & a1 & a2);
  endtask

  task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
    logic a0;
    logic a1;
    logic a2;
    mst.start_cond();
    mst.byte_out({SCRB_DEV_ADDR_HI, strap, 1'b0}, a0);
    mst.byte_out(ofs, a1);
    mst.start_cond();
    mst.byte_out({SCRB_DEV_ADDR_HI, strap, 1'b1}, a2);
    mst.byte_in(1'b0, rd_v);
    mst.stop_cond();
    chk_ack("read ack", 1'b1, a0 & a1 & a2);
    chk_val("read data", {8'h00, exp}, {8'h00, rd_v});
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (90000) @(posedge ref_clk);
    err_total++;
    finish_test();
  end

  // ------------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------------
  initial
  begin
    do_reset();
    chk_ack("lock at reset", 1'b0, lock_w);
    chk_val("fast select", 16'h0001, {12'h000, cfg_w.fast_source_sel});
    chk_val("side port", 16'h0001, {12'h000, cfg_w.side_common_port});
    chk_val("drive", 16'h0003, {14'h0, cfg_w.output_term_on, cfg_w.output_drive_level});
    mst.start_cond();
    mst.byte_out({SCRB_DEV_ADDR_HI, 3'h4, 1'b0}, ack_v);
    mst.stop_cond();
    chk_ack("foreign ack", 1'b0, ack_v);
    chk_ack("lock foreign", 1'b0, lock_w);
    for (int i = 0; i < 8; i++)
      rd(OFS_TAB[i], RST_TAB[i]);
    chk_ack("lock after access", 1'b1, lock_w);
    for (int c = 0; c < 4; c++)
    begin
      wr(SCRB_OFS_FAST, {6'h10, c[1:0]});
      wr(SCRB_OFS_SIDE, {6'h10, c[1:0]});
      chk_val("fast select", 16'h1 << c, {12'h000, cfg_w.fast_source_sel});
      chk_val("side port", 16'h1 << c, {12'h000, cfg_w.side_common_port});
      chk_val("fast pick", {14'h0, c[1:0]}, {14'h0, cfg_w.fast_source_pick});
      chk_val("side pick", {14'h0, c[1:0]}, {14'h0, cfg_w.side_source_pick});
      chk_val("paths on", 16'h0005, {13'h0, cfg_w.fast_path_on, cfg_w.fast_standby,
              cfg_w.side_path_on});
    end
    wr(SCRB_OFS_FAST, 8'hFF);
    rd(SCRB_OFS_FAST, 8'h43);
    wr(SCRB_OFS_FAST, 8'h00);
    chk_val("fast off", 16'h0010,
            {10'h0, cfg_w.fast_path_on, cfg_w.fast_standby, cfg_w.fast_source_sel});
    wr(SCRB_OFS_SIDE, 8'h00);
    chk_val("side off", 16'h0000, {11'h0, cfg_w.side_path_on, cfg_w.side_common_port});
    wr(SCRB_OFS_TERM_LO, 8'hA5);
    wr(SCRB_OFS_TERM_HI, 8'h3C);
    chk_val("lane term", 16'h3CA5, cfg_w.input_term_per_lane);
    wr(SCRB_OFS_TERM_M, 8'hFE);
    chk_val("term master off", 16'h0000, cfg_w.input_term_per_lane);
    rd(SCRB_OFS_TERM_M, 8'h00);
    rd(SCRB_OFS_TERM_HI, 8'h3C);
    wr(SCRB_OFS_EQ_LO, 8'h5A);
    wr(SCRB_OFS_EQ_HI, 8'hC3);
    chk_val("eq level", 16'hC35A, cfg_w.input_eq_level);
    for (int v = 0; v < 16; v++)
    begin
      wr(SCRB_OFS_DRIVE, {4'h0, v[3:0]});
      chk_val("drive fields", {12'h000, v[3:0]}, {12'h000, cfg_w.output_boost_level,
              cfg_w.output_term_on, cfg_w.output_drive_level});
    end
    wr(SCRB_OFS_DRIVE, 8'hFF);
    rd(SCRB_OFS_DRIVE, 8'h0F);
    wr(8'h05, 8'h77);
    rd(8'h05, 8'h00);
    strap  = 3'h2;
    mst.hp = 8;
    wr(SCRB_OFS_EQ_LO, 8'h81);
    rd(SCRB_OFS_EQ_LO, 8'h81);
    mst.hp = 2;
    do_reset();
    chk_ack("lock second reset", 1'b0, lock_w);
    rd(SCRB_OFS_FAST, 8'h40);
    finish_test();
  end
endmodule
`default_nettype wire
